/* File: verilog/table_access_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and carriers for the table pointer access unit
// Assumes: One core clock; four phases per instruction cycle
// Notes:   Phase is a 2-bit binary count; state encoding is the enum default
//////////////////////////////////////////////////////////////////////////////
package table_access_pkg;

	localparam int          PTR_W        = 21;
	localparam int          HOLD_N       = 8;
	localparam int          HOLD_SEL_W   = 3;
	localparam int          PHASE_N      = 4;
	localparam logic [11:0] OP_PREFIX    = 12'h000;
	localparam logic [1:0]  OP_KIND_RD   = 2'h2;
	localparam logic [1:0]  OP_KIND_WR   = 2'h3;
	localparam logic [1:0]  MODE_KEEP    = 2'h0;
	localparam logic [1:0]  MODE_POSTINC = 2'h1;
	localparam logic [1:0]  MODE_POSTDEC = 2'h2;
	localparam logic [1:0]  MODE_PREINC  = 2'h3;
	localparam logic [20:0] PTR_RESET    = 21'h000000;
	localparam logic [7:0]  LATCH_RESET  = 8'h00;
	localparam logic [7:0]  HOLD_RESET   = 8'hff;
	localparam logic [1:0]  PHASE_LAST   = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC1,
		ST_EXEC2
	} table_state_e;

	typedef struct packed {
		logic [PTR_W-1:0] addr;
		logic             rd;
	} pmem_req_s;

	typedef struct packed {
		table_state_e         state;
		logic [1:0]           phase;
		logic                 is_write;
		logic [1:0]           mode;
		logic [PTR_W-1:0]     table_byte_pointer;
		logic [7:0]           table_latch;
		logic [HOLD_N-1:0][7:0] hold;
		pmem_req_s            req;
	} table_unit_s;

endpackage : table_access_pkg

/* File: verilog/table_pointer_access_unit.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Executes table read and table write instructions of the core
// Assumes: Decoder presents an opcode with op_valid on phase 0 of a cycle
// Notes:   Program memory answers combinationally in the same clock
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Table read loads the byte at the pointer into the latch.
// - Pointer is 21 bits, one byte per address, 2 Mbyte range.
// - Pointer bit 0 chooses low (0) or high (1) byte of a word.
// - Read opcode is twelve zeros, 10, then a two-bit pointer mode.
// - Post modes access then step; pre-increment steps then accesses.
// - Neither operation changes any arithmetic status flag.
// - Write opcode is twelve zeros, 11, then the same two-bit mode.
// - Write copies the latch into holding register picked by pointer bits 2:0.
// - Write updates the pointer per mode, pre-increment before selection.
// - Holding registers only stage data for a later programming sequence.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps

module table_pointer_access_unit
	import table_access_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	input  wire logic                     op_valid,
	input  wire logic [15:0]              opcode,
	input  wire logic                     ptr_load,
	input  wire logic [PTR_W-1:0]         ptr_load_value,
	input  wire logic                     latch_load,
	input  wire logic [7:0]               latch_load_value,
	input  wire logic [7:0]               pmem_rdata,
	output logic                          op_accept,
	output logic                          busy,
	output logic                          status_write_en,
	output logic                          pmem_rd,
	output logic [PTR_W-1:0]              pmem_addr,
	output logic [PTR_W-1:0]              table_byte_pointer,
	output logic [7:0]                    table_latch,
	output logic [HOLD_N-1:0][7:0]        hold_data
);

	table_unit_s cur;
	table_unit_s next_cur;
	logic        is_tbl;

	////////////////////////////////////////////////////////////////////////
	// Pointer step with natural wrap at the 21-bit boundary
	function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p,
	                                              input logic             up);
		ptr_step = up ? p + 21'h000001 : p - 21'h000001;
	endfunction : ptr_step

	assign is_tbl = (opcode[15:4] == OP_PREFIX) && opcode[3];
	assign op_accept = op_valid && is_tbl && (cur.state == ST_IDLE)
	                   && (cur.phase == 2'h0);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_cur = cur;
		next_cur.phase = cur.phase + 2'h1;
		next_cur.req.rd = 1'b0;
		// Software writes to the pointer and latch only land while idle
		if (cur.state == ST_IDLE && ptr_load) begin
			next_cur.table_byte_pointer = ptr_load_value;
		end
		if (cur.state == ST_IDLE && latch_load) begin
			next_cur.table_latch = latch_load_value;
		end
		case (cur.state)
			ST_IDLE: begin
				if (op_accept) begin
					next_cur.state = ST_EXEC1;
					next_cur.is_write = (opcode[3:2] == OP_KIND_WR);
					next_cur.mode = opcode[1:0];
				end
			end
			ST_EXEC1: begin
				if (cur.phase == PHASE_LAST) begin
					next_cur.state = ST_EXEC2;
					// Pre-increment steps before the access so it selects the new byte
					if (cur.mode == MODE_PREINC) begin
						next_cur.table_byte_pointer = ptr_step(cur.table_byte_pointer, 1'b1);
					end
				end
			end
			ST_EXEC2: begin
				next_cur.req.addr = cur.table_byte_pointer;
				next_cur.req.rd = !cur.is_write && (cur.phase == 2'h0);
				if (cur.phase == PHASE_LAST) begin
					next_cur.state = ST_IDLE;
					if (cur.is_write) begin
						next_cur.hold[cur.table_byte_pointer[HOLD_SEL_W-1:0]] = cur.table_latch;
					end else begin
						next_cur.table_latch = pmem_rdata;
					end
					if (cur.mode == MODE_POSTINC) begin
						next_cur.table_byte_pointer = ptr_step(cur.table_byte_pointer, 1'b1);
					end else if (cur.mode == MODE_POSTDEC) begin
						next_cur.table_byte_pointer = ptr_step(cur.table_byte_pointer, 1'b0);
					end
				end
			end
			default: begin
				next_cur.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cur.state <= ST_IDLE;
			cur.phase <= 2'h0;
			cur.is_write <= 1'b0;
			cur.mode <= MODE_KEEP;
			cur.table_byte_pointer <= PTR_RESET;
			cur.table_latch <= LATCH_RESET;
			cur.hold <= {HOLD_N{HOLD_RESET}};
			cur.req <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign busy = (cur.state != ST_IDLE);
	assign status_write_en = 1'b0;
	// Memory address is held throughout the access cycle and, for a table read only, read is enabled in all four of its phases
	assign pmem_addr = (cur.state == ST_EXEC2) ? cur.table_byte_pointer : cur.req.addr;
	assign pmem_rd = (cur.state == ST_EXEC2) && !cur.is_write;
	assign table_byte_pointer = cur.table_byte_pointer;
	assign table_latch = cur.table_latch;
	assign hold_data = cur.hold;

	////////////////////////////////////////////////////////////////////////
	sequence start_op_s;
		op_accept;
	endsequence

	sequence two_cycles_s;
		##8 (cur.state == ST_IDLE);
	endsequence

	// Accept clock is the decode phase itself, so busy covers the other seven
	op_two_cycles_a: assert property (@(posedge core_clk) disable iff (!nrst)
		start_op_s |-> ##1 busy [*7] ##1 !busy)
		else $error("Table op did not last two cycles");

	op_length_w_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(op_accept && opcode[3:2] == OP_KIND_WR) |-> two_cycles_s)
		else $error("Table write length wrong");

	read_latch_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(cur.state == ST_EXEC2 && !cur.is_write && cur.phase == PHASE_LAST)
		|=> table_latch == $past(pmem_rdata))
		else $error("Latch not loaded from memory");

	hold_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(cur.state == ST_EXEC2 && cur.is_write && cur.phase == PHASE_LAST)
		|=> hold_data[$past(table_byte_pointer[2:0])] == $past(table_latch))
		else $error("Holding register not written");

	post_inc_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(op_accept && opcode[1:0] == MODE_POSTINC)
		|-> ##8 table_byte_pointer == $past(table_byte_pointer, 8) + 21'h000001)
		else $error("Post-increment wrong");

	post_dec_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(op_accept && opcode[1:0] == MODE_POSTDEC)
		|-> ##8 table_byte_pointer == $past(table_byte_pointer, 8) - 21'h000001)
		else $error("Post-decrement wrong");

	pre_inc_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(op_accept && opcode[1:0] == MODE_PREINC)
		|-> ##5 pmem_addr == $past(table_byte_pointer, 5) + 21'h000001)
		else $error("Pre-increment access address wrong");

	keep_ptr_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(op_accept && opcode[1:0] == MODE_KEEP && !ptr_load)
		|-> ##8 table_byte_pointer == $past(table_byte_pointer, 8))
		else $error("Pointer moved in no-change mode");

	decode_a: assert property (@(posedge core_clk) disable iff (!nrst)
		op_accept |-> opcode[15:4] == 12'h000 && opcode[3])
		else $error("Non-table opcode accepted");

	no_status_a: assert property (@(posedge core_clk) disable iff (!nrst)
		busy |-> !status_write_en)
		else $error("Status write during table op");

endmodule : table_pointer_access_unit

/* File: dv/pmem_model.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Program memory model behind the table access unit
// Assumes: Byte content is a fixed function of its address
// Notes:   Toggles junk while not read, so a stale byte never passes
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module pmem_model
	import table_access_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             pmem_rd,
	input  wire logic [PTR_W-1:0] pmem_addr,
	output logic      [7:0]       pmem_rdata
);
	logic [7:0] junk = 8'h00;
	always @(posedge core_clk) junk <= ~junk;
	assign pmem_rdata = pmem_rd ? (pmem_addr[7:0] ^ pmem_addr[15:8] ^ {3'h0, pmem_addr[20:16]}) : junk;
endmodule : pmem_model

/* File: dv/testbench.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the table access unit
// Assumes: Ops retried at falling edges until op_accept is seen
// Notes:   Expected state kept in a shadow model, checked when busy drops
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module testbench
	import table_access_pkg::*;
;
	typedef struct packed {
		logic [PTR_W-1:0]       ptr;
		logic [7:0]             lat;
		logic [HOLD_N-1:0][7:0] hold;
	} result_s;
	logic                   core_clk = 1'b0, nrst = 1'b0, op_valid = 1'b0, ptr_load = 1'b0;
	logic                   latch_load = 1'b0, op_accept, busy, status_write_en, pmem_rd;
	logic [15:0]            opcode = 16'h0000;
	logic [PTR_W-1:0]       ptr_load_value = '0, pmem_addr, table_byte_pointer;
	logic [7:0]             latch_load_value = 8'h00, pmem_rdata, table_latch;
	logic [HOLD_N-1:0][7:0] hold_data;
	result_s                exp_q[$], model;
	int                     errors = 0, num_checks = 0, cycles = 0, blen = 0;
	integer                 seed = 32'hf0b3, r;
	logic                   busy_d = 1'b0;

	always #5 core_clk = ~core_clk;

	table_pointer_access_unit dut_u (.core_clk(core_clk), .nrst(nrst), .op_valid(op_valid),
		.opcode(opcode), .ptr_load(ptr_load), .ptr_load_value(ptr_load_value),
		.latch_load(latch_load), .latch_load_value(latch_load_value), .pmem_rdata(pmem_rdata),
		.op_accept(op_accept), .busy(busy), .status_write_en(status_write_en),
		.pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .table_byte_pointer(table_byte_pointer),
		.table_latch(table_latch), .hold_data(hold_data));
	pmem_model pmem_u (.core_clk(core_clk), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr),
		.pmem_rdata(pmem_rdata));

	//////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] mem_byte(input logic [PTR_W-1:0] a);
		return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
	endfunction : mem_byte

	task automatic check_bit(input logic got, input logic want);
		num_checks++;
		if (got !== want) begin
			errors++;
			$display("Error %0t: flag mismatch", $time);
		end
	endtask : check_bit

	task automatic check_res(input result_s want);
		num_checks++;
		if ({table_byte_pointer, table_latch, hold_data} !== want) begin
			errors++;
			$display("Error %0t: state mismatch", $time);
		end
	endtask : check_res

	task automatic load(input logic [31:0] p, input logic [31:0] l);
		ptr_load = 1'b1;
		latch_load = 1'b1;
		ptr_load_value = p[PTR_W-1:0];
		latch_load_value = l[7:0];
		@(negedge core_clk);
		ptr_load = 1'b0;
		latch_load = 1'b0;
		model.ptr = p[PTR_W-1:0];
		model.lat = l[7:0];
		check_res(model);
	endtask : load

	task automatic run_op(input logic wr, input logic [1:0] mode);
		logic [PTR_W-1:0] eff;
		int               n;
		eff = (mode == MODE_PREINC) ? model.ptr + 1'b1 : model.ptr;
		if (wr) model.hold[eff[2:0]] = model.lat;
		else model.lat = mem_byte(eff);
		if (mode == MODE_POSTDEC) model.ptr = model.ptr - 1'b1;
		else if (mode != MODE_KEEP) model.ptr = model.ptr + 1'b1;
		opcode = {12'h000, 1'b1, wr, mode};
		op_valid = 1'b1;
		n = 0;
		#1;
		while (op_accept !== 1'b1 && n < 8) begin
			@(negedge core_clk);
			n++;
			#1;
		end
		check_bit(op_accept, 1'b1);
		exp_q.push_back(model);
		@(negedge core_clk);
		op_valid = 1'b0;
		ptr_load = 1'b1;
		ptr_load_value = ~model.ptr;
		@(negedge core_clk);
		ptr_load = 1'b0;
		n = 0;
		while (busy !== 1'b0 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
	endtask : run_op

	task report_and_stop;
		$display("errors=%0d num_checks=%0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	//////////////////////////////////////////////////////////////////////////////
	always @(negedge core_clk) begin
		if (busy === 1'b1) blen++;
		if (busy_d === 1'b1 && busy === 1'b0) begin
			check_bit(blen == 7, 1'b1);
			if (exp_q.size() > 0) check_res(exp_q.pop_front());
			else check_bit(1'b0, 1'b1);
			blen = 0;
		end
		check_bit(status_write_en, 1'b0);
		busy_d = busy;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		model = '{ptr: PTR_RESET, lat: LATCH_RESET, hold: {HOLD_N{HOLD_RESET}}};
		repeat (10) @(negedge core_clk);
		nrst = 1'b1;
		check_res(model);
		for (int i = 0; i < 16; i++) begin
			load($random(seed), $random(seed));
			run_op(i[3], i[1:0]);
		end
		load(32'h001fffff, $random(seed));
		run_op(1'b0, MODE_POSTINC);
		run_op(1'b1, MODE_POSTDEC);
		for (int i = 0; i < 24; i++) begin
			r = $random(seed);
			run_op(r[2], r[1:0]);
		end
		opcode = 16'h0007;
		op_valid = 1'b1;
		repeat (6) @(negedge core_clk) check_bit(op_accept, 1'b0);
		opcode = 16'h0108;
		repeat (6) @(negedge core_clk) check_bit(op_accept, 1'b0);
		op_valid = 1'b0;
		repeat (12) @(negedge core_clk);
		check_res(model);
		report_and_stop();
	end
endmodule : testbench
